// file: masked_reg.sv
// One software reset control register with capability masked writes.
// Assumes the caller qualifies wr_en with a complete bus write.
`timescale 1ns/1ps
`include "periph_reset_defines.svh"

module masked_reg (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Write side
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_strb,
  input  wire logic [31:0] cap_mask,
  input  wire logic [31:0] impl_mask,
  // Stored value
  output logic      [31:0] value_ff
);

  logic [31:0] nxt_value;
  logic [31:0] lane_mask;
  logic [31:0] write_mask;

  // Expand byte strobes into a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wr_strb[lane]}};
    end
  endgenerate

  // Only implemented, present and strobed bits take the new value
  assign write_mask = lane_mask & cap_mask & impl_mask;
  assign nxt_value  = (value_ff & ~write_mask) | (wr_data & write_mask);

  // Cleared on system reset so no peripheral starts held in reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      value_ff <= `ZERO_WORD;
    end else if (wr_en) begin
      value_ff <= nxt_value;
    end
  end

endmodule : masked_reg

// file: periph_reset_defines.svh
// Constants for the peripheral soft reset controller.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`ifndef PERIPH_RESET_DEFINES_SVH
`define PERIPH_RESET_DEFINES_SVH

// Register byte offsets
`define PERIPH_RST_ONE_OFS   12'h044
`define PORT_RST_OFS         12'h048
`define CAP_MASK_TWO_OFS     12'h050
`define CAP_MASK_FOUR_OFS    12'h054

// Register layout
`define ADDR_W               12
`define ADDR_LSB             2
`define ZERO_WORD            32'h0000_0000
`define PERIPH_RST_ONE_RST   32'h0000_0000
`define PORT_RST_RST         32'h0000_0000
`define PERIPH_RST_ONE_IMPL  32'h0107_0113
`define PORT_RST_IMPL        32'h0000_001F
`define CAP_MASK_TWO_RST     32'h0107_0113
`define CAP_MASK_FOUR_RST    32'h0000_001F

// Field positions
`define BIT_SERIAL0          0
`define BIT_SERIAL1          1
`define BIT_SYNC0            4
`define BIT_QUAD0            8
`define BIT_GP_TIMER_ZERO_RESET           16
`define BIT_GP_TIMER_ONE_RESET           17
`define BIT_GP_TIMER_TWO_RESET           18
`define BIT_COMPARATOR_ZERO_RESET            24
`define PORT_COUNT           5

// AXI responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// file: periph_reset_pkg.sv
// Types for the peripheral soft reset controller.
// Assumes the defines header supplies all numeric constants.
package periph_reset_pkg;

  // Registers that the bus can reach
  typedef enum logic [2:0] {
    REG_PERIPH_ONE,
    REG_PORT,
    REG_CAP_TWO,
    REG_CAP_FOUR,
    REG_NONE
  } reg_sel_t;

endpackage : periph_reset_pkg

// file: peripheral_soft_reset_ctrl.sv
// Software reset controller for on-chip peripherals and I/O ports.
// Assumes an AXI4-Lite master on the system clock; capability masks
// are registers written over that bus and reset outputs feed the units.
`timescale 1ns/1ps
`include "periph_reset_defines.svh"

// What this block does
// R1 - Writes to the first reset register are masked by capability mask two.
// R2 - Writes to the port reset register are masked by capability mask four.
// R3 - Both reset registers clear to zero on system reset.
// R4 - Bit 8 of the first register holds quadrature decoder 0 in reset.
// R5 - Bit 4 of the first register holds synchronous serial unit 0 in reset.
// R6 - Bits 1 and 0 of the first register reset async serial units 1 and 0.
// R7 - Bits 4 to 0 of the port register reset ports E, D, C, B and A.
// R8 - Reserved bits are read-only zero and software preserves them.
// R9 - Bits 18-16 reset timers 2-0 and bit 24 resets comparator 0.
// R10 - A bit at one holds its unit in reset and clearing it releases it.
module peripheral_soft_reset_ctrl
  import periph_reset_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Peripheral reset outputs, active high
  output logic             async_serial_zero_reset,
  output logic             async_serial_one_reset,
  output logic             sync_serial_zero_reset,
  output logic             quad_decoder_zero_reset,
  output logic             gp_timer_zero_reset,
  output logic             gp_timer_one_reset,
  output logic             gp_timer_two_reset,
  output logic             comparator_zero_reset,
  output logic             port_a_reset,
  output logic             port_b_reset,
  output logic             port_c_reset,
  output logic             port_d_reset,
  output logic             port_e_reset
);

  // Address decode shared by the read and write paths
  function automatic reg_sel_t decode(input logic [11:0] addr);
    if (addr[`ADDR_LSB-1:0] != 2'b00) begin
      decode = REG_NONE;
    end else begin
      unique case (addr)
        `PERIPH_RST_ONE_OFS: decode = REG_PERIPH_ONE;
        `PORT_RST_OFS:       decode = REG_PORT;
        `CAP_MASK_TWO_OFS:   decode = REG_CAP_TWO;
        `CAP_MASK_FOUR_OFS:  decode = REG_CAP_FOUR;
        default:             decode = REG_NONE;
      endcase
    end
  endfunction : decode

  logic [11:0] aw_addr_ff;
  logic        aw_held_ff;
  logic [31:0] w_data_ff;
  logic [3:0]  w_strb_ff;
  logic        w_held_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] cap_two_ff;
  logic [31:0] cap_four_ff;
  logic [31:0] periph_one_ff;
  logic [31:0] port_ff;
  logic        do_write;
  reg_sel_t    wr_sel;
  reg_sel_t    rd_sel;
  logic [31:0] strb_mask;

  // Byte strobes widened to bits so mask writes honour lanes as well
  assign strb_mask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                      {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

  // Each channel accepts once per write; no new write until B is taken
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_sel        = decode(aw_addr_ff);
  assign rd_sel        = decode(s_axi_araddr);

  // Write address capture
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_addr_ff <= 12'h000;
      aw_held_ff <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr_ff <= s_axi_awaddr;
      aw_held_ff <= 1'b1;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  // Write data capture, independent of address order
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      w_data_ff <= `ZERO_WORD;
      w_strb_ff <= 4'h0;
      w_held_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
      w_held_ff <= 1'b1;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wr_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Capability masks, written by system control software at boot.
  // Kept here so writes can be gated without an extra port.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cap_two_ff  <= `CAP_MASK_TWO_RST;
      cap_four_ff <= `CAP_MASK_FOUR_RST;
    end else if (do_write && wr_sel == REG_CAP_TWO) begin
      cap_two_ff  <= (cap_two_ff & ~(strb_mask & `PERIPH_RST_ONE_IMPL))
                     | (w_data_ff & strb_mask & `PERIPH_RST_ONE_IMPL);
    end else if (do_write && wr_sel == REG_CAP_FOUR) begin
      cap_four_ff <= (cap_four_ff & ~(strb_mask & `PORT_RST_IMPL))
                     | (w_data_ff & strb_mask & `PORT_RST_IMPL);
    end
  end

  // First reset register, gated by capability mask two
  masked_reg u_periph_one (
    .clock     (clock),
    .rst_b     (rst_b),                                  // R3
    .wr_en     (do_write && wr_sel == REG_PERIPH_ONE),
    .wr_data   (w_data_ff),
    .wr_strb   (w_strb_ff),
    .cap_mask  (cap_two_ff),                             // R1
    .impl_mask (`PERIPH_RST_ONE_IMPL),                   // R8
    .value_ff  (periph_one_ff)
  );

  // Port reset register, gated by capability mask four
  masked_reg u_port (
    .clock     (clock),
    .rst_b     (rst_b),                                  // R3
    .wr_en     (do_write && wr_sel == REG_PORT),
    .wr_data   (w_data_ff),
    .wr_strb   (w_strb_ff),
    .cap_mask  (cap_four_ff),                            // R2
    .impl_mask (`PORT_RST_IMPL),                         // R8
    .value_ff  (port_ff)
  );

  // Read data is registered; reserved bits are never stored so read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= `ZERO_WORD;
      rresp_ff  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= (rd_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      unique case (rd_sel)
        REG_PERIPH_ONE: rdata_ff <= periph_one_ff;       // R8
        REG_PORT:       rdata_ff <= port_ff;             // R8
        REG_CAP_TWO:    rdata_ff <= cap_two_ff;
        REG_CAP_FOUR:   rdata_ff <= cap_four_ff;
        REG_NONE:       rdata_ff <= `ZERO_WORD;
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Reset outputs follow the stored bits directly: one holds, zero frees
  assign quad_decoder_zero_reset = periph_one_ff[`BIT_QUAD0];     // R4 R10
  assign sync_serial_zero_reset  = periph_one_ff[`BIT_SYNC0];     // R5 R10
  assign async_serial_one_reset  = periph_one_ff[`BIT_SERIAL1];   // R6
  assign async_serial_zero_reset = periph_one_ff[`BIT_SERIAL0];   // R6
  assign gp_timer_two_reset      = periph_one_ff[`BIT_GP_TIMER_TWO_RESET];    // R9
  assign gp_timer_one_reset      = periph_one_ff[`BIT_GP_TIMER_ONE_RESET];    // R9
  assign gp_timer_zero_reset     = periph_one_ff[`BIT_GP_TIMER_ZERO_RESET];    // R9
  assign comparator_zero_reset   = periph_one_ff[`BIT_COMPARATOR_ZERO_RESET];     // R9

  // Port resets, bit 0 is port A up to bit 4 for port E
  assign port_a_reset = port_ff[0];                               // R7
  assign port_b_reset = port_ff[1];                               // R7
  assign port_c_reset = port_ff[2];                               // R7
  assign port_d_reset = port_ff[3];                               // R7
  assign port_e_reset = port_ff[`PORT_COUNT-1];                   // R7

endmodule : peripheral_soft_reset_ctrl

// file: peripheral_soft_reset_ctrl_test.sv
// Self-checking bench for the peripheral soft reset controller.
// Assumes a 50 MHz clock and an AXI4-Lite master driven from here.
`timescale 1ns/1ps
`include "periph_reset_defines.svh"
module peripheral_soft_reset_ctrl_test;
  logic        clock, rst_b, aw_v, w_v, b_rdy, ar_v, r_rdy;
  logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [11:0] aw_a, ar_a, a;
  logic [31:0] w_d, r_d, d, g;
  logic [3:0]  w_s, s;
  logic [1:0]  b_rs, r_rs, r;
  wire  [12:0] ro;
  int          m1, m2, c2, c4, seed, i, cyc, bad_count, checks_done;
  logic [11:0] adr [5] = '{12'h044, 12'h048, 12'h050, 12'h054, 12'h0F0};
  peripheral_soft_reset_ctrl dut (
    .clock(clock), .rst_b(rst_b), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
    .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_rdy),
    .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rs),
    .s_axi_rvalid(r_v), .s_axi_rready(r_rdy),
    .async_serial_zero_reset(ro[0]), .async_serial_one_reset(ro[1]),
    .sync_serial_zero_reset(ro[2]), .quad_decoder_zero_reset(ro[3]),
    .gp_timer_zero_reset(ro[4]), .gp_timer_one_reset(ro[5]),
    .gp_timer_two_reset(ro[6]), .comparator_zero_reset(ro[7]),
    .port_a_reset(ro[8]), .port_b_reset(ro[9]), .port_c_reset(ro[10]),
    .port_d_reset(ro[11]), .port_e_reset(ro[12]));
  // Free-running system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Bus response codes
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  // Reset output pins, rebuilt into one word
  task automatic chk_out(input logic [12:0] got, input logic [31:0] exp);
    chk({19'h0, got}, exp);
  endtask : chk_out
  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [11:0] wa, input logic [31:0] wd,
                    input logic [3:0] ws, output logic [1:0] wr_r);
    logic ta, tw, tb;
    aw_a <= wa; w_d <= wd; w_s <= ws; aw_v <= 1; w_v <= 1; b_rdy <= 1;
    tb = 0;
    while (!tb) begin
      // Handshakes read mid-cycle, where the ready levels have settled
      @(negedge clock);
      ta = aw_v && aw_rdy; tw = w_v && w_rdy; tb = b_v; wr_r = b_rs;
      @(posedge clock);
      if (ta) aw_v <= 0;
      if (tw) w_v <= 0;
    end
    b_rdy <= 0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [11:0] ra, output logic [31:0] rdv,
                    output logic [1:0] rd_r);
    logic ta, tr;
    ar_a <= ra; ar_v <= 1; r_rdy <= 1;
    tr = 0;
    while (!tr) begin
      @(negedge clock);
      ta = ar_v && ar_rdy; tr = r_v; rdv = r_d; rd_r = r_rs;
      @(posedge clock);
      if (ta) ar_v <= 0;
    end
    r_rdy <= 0;
    @(posedge clock);
  endtask : rd
  // Reference model: capability masks only ever hold implemented bits
  function automatic logic [31:0] mrd(input logic [11:0] ma);
    case (ma)
      12'h044: return m1;
      12'h048: return m2;
      12'h050: return c2;
      12'h054: return c4;
      default: return 32'h0;
    endcase
  endfunction : mrd
  function automatic logic [1:0] rsp(input logic [11:0] ma);
    return (ma inside {12'h044, 12'h048, 12'h050, 12'h054}) ? `RESP_OKAY
      : `RESP_SLVERR;
  endfunction : rsp
  task automatic mwr(input logic [11:0] ma, input int md, input int ms);
    int m;
    m = 0;
    for (int k = 0; k < 4; k++) if (ms[k]) m |= 255 << (8 * k);
    case (ma)
      12'h044: m1 = (m1 & ~(m & c2)) | (md & m & c2);
      12'h048: m2 = (m2 & ~(m & c4)) | (md & m & c4);
      12'h050: c2 = (c2 & ~(m & `PERIPH_RST_ONE_IMPL))
                    | (md & m & `PERIPH_RST_ONE_IMPL);
      12'h054: c4 = (c4 & ~(m & `PORT_RST_IMPL)) | (md & m & `PORT_RST_IMPL);
      default: ;
    endcase
  endtask : mwr
  task automatic mres;
    m1 = 0; m2 = 0; c2 = `CAP_MASK_TWO_RST; c4 = `CAP_MASK_FOUR_RST;
  endtask : mres
  function automatic logic [31:0] xo;
    return {19'h0, m2[4:0], m1[24], m1[18:16], m1[8], m1[4], m1[1:0]};
  endfunction : xo
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial begin
    seed = 91; bad_count = 0; checks_done = 0; cyc = 0;
    rst_b = 0; aw_v = 0; w_v = 0; b_rdy = 0; ar_v = 0; r_rdy = 0;
    aw_a = 12'h000; ar_a = 12'h000; w_d = 32'h0; w_s = 4'h0;
    mres;
    repeat (6) @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    for (i = 0; i < 5; i++) begin
      rd(adr[i], g, r);
      chk(g, mrd(adr[i]));
      chk_resp(r, rsp(adr[i]));
    end
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      a = (i < 10) ? adr[i % 5] : adr[d[6:4] % 5];
      s = (i < 10) ? 4'hF : d[3:0];
      d = (i < 5) ? 32'hFFFF_FFFF : $random(seed);
      wr(a, d, s, r);
      chk_resp(r, rsp(a));
      mwr(a, d, s);
      chk_out(ro, xo());
      rd(a, g, r);
      chk(g, mrd(a));
    end
    // Reset in mid-run must drop every hold at once
    // Open the mask first so the reset has holds to drop
    wr(12'h050, 32'hFFFF_FFFF, 4'hF, r);
    mwr(12'h050, 32'hFFFF_FFFF, 4'hF);
    wr(12'h044, 32'hFFFF_FFFF, 4'hF, r);
    mwr(12'h044, 32'hFFFF_FFFF, 4'hF);
    chk_out(ro, xo());
    rst_b <= 0;
    @(negedge clock);
    mres;
    chk_out(ro, xo());
    @(posedge clock);
    rst_b <= 1;
    @(posedge clock);
    rd(12'h044, g, r);
    chk(g, mrd(12'h044));
    tally_and_finish;
  end
endmodule : peripheral_soft_reset_ctrl_test
bind peripheral_soft_reset_ctrl psrc_monitor mon (
  .clock(clock), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .async_serial_zero_reset(async_serial_zero_reset),
  .async_serial_one_reset(async_serial_one_reset),
  .sync_serial_zero_reset(sync_serial_zero_reset),
  .quad_decoder_zero_reset(quad_decoder_zero_reset),
  .gp_timer_zero_reset(gp_timer_zero_reset),
  .gp_timer_one_reset(gp_timer_one_reset),
  .gp_timer_two_reset(gp_timer_two_reset),
  .comparator_zero_reset(comparator_zero_reset),
  .port_a_reset(port_a_reset), .port_b_reset(port_b_reset),
  .port_c_reset(port_c_reset), .port_d_reset(port_d_reset),
  .port_e_reset(port_e_reset));

// file: psrc_monitor.sv
// Port checker for the peripheral soft reset controller.
// Assumes it is bound to the controller top on one clock.
`timescale 1ns/1ps
`include "periph_reset_defines.svh"
module psrc_monitor (
  // Clock, reset and bus
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // Reset outputs
  input wire logic        async_serial_zero_reset,
  input wire logic        async_serial_one_reset,
  input wire logic        sync_serial_zero_reset,
  input wire logic        quad_decoder_zero_reset,
  input wire logic        gp_timer_zero_reset,
  input wire logic        gp_timer_one_reset,
  input wire logic        gp_timer_two_reset,
  input wire logic        comparator_zero_reset,
  input wire logic        port_a_reset,
  input wire logic        port_b_reset,
  input wire logic        port_c_reset,
  input wire logic        port_d_reset,
  input wire logic        port_e_reset
);
  logic [11:0] wa_ff;
  logic [11:0] ra_ff;
  logic [31:0] one_v;
  logic [31:0] port_v;
  // Outputs rebuilt in register bit order
  assign one_v = {7'h0, comparator_zero_reset, 5'h0, gp_timer_two_reset,
    gp_timer_one_reset, gp_timer_zero_reset, 7'h0, quad_decoder_zero_reset,
    3'h0, sync_serial_zero_reset, 2'h0, async_serial_one_reset,
    async_serial_zero_reset};
  assign port_v = {27'h0, port_e_reset, port_d_reset, port_c_reset,
    port_b_reset, port_a_reset};
  // Addresses of accepted requests; they stand until the answer goes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wa_ff <= 12'h000;
      ra_ff <= 12'h000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ra_ff <= s_axi_araddr;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_one_clear: assert property ($rose(rst_b) |-> one_v == 32'h0)
    else $error("peripheral resets not clear after reset");
  a_port_clear: assert property ($rose(rst_b) |-> port_v == 32'h0)
    else $error("port resets not clear after reset");
  a_one_hold: assert property (rst_b && !($rose(s_axi_bvalid) &&
    wa_ff == `PERIPH_RST_ONE_OFS) |-> $stable(one_v))
    else $error("peripheral resets moved without a write");
  a_port_hold: assert property (rst_b && !($rose(s_axi_bvalid) &&
    wa_ff == `PORT_RST_OFS) |-> $stable(port_v))
    else $error("port resets moved without a write");
  a_one_map: assert property ($rose(s_axi_rvalid) &&
    ra_ff == `PERIPH_RST_ONE_OFS |-> s_axi_rdata == $past(one_v))
    else $error("peripheral reset read differs from outputs");
  a_port_map: assert property ($rose(s_axi_rvalid) &&
    ra_ff == `PORT_RST_OFS |-> s_axi_rdata == $past(port_v))
    else $error("port reset read differs from outputs");
  a_one_resv: assert property (s_axi_rvalid &&
    ra_ff == `PERIPH_RST_ONE_OFS |->
    (s_axi_rdata & ~`PERIPH_RST_ONE_IMPL) == 32'h0)
    else $error("reserved peripheral bits read nonzero");
  a_port_resv: assert property (s_axi_rvalid && ra_ff == `PORT_RST_OFS
    |-> s_axi_rdata[31:5] == 27'h0)
    else $error("reserved port bits read nonzero");
  c_one_wr: cover property ($rose(s_axi_bvalid) && wa_ff == 12'h044);
  c_port_rd: cover property ($rose(s_axi_rvalid) && ra_ff == 12'h048);
  c_both_held: cover property (one_v != 32'h0 && port_v != 32'h0);
endmodule : psrc_monitor
